// ==== core/php_consts.svh ====
// How it works
// R1: while the init input is low every internal register is cleared to zero.
// R2: transfers happen only on a phase-two pulse, never outside it.
// R3: direction high reads from the device, low writes into it.
// R4: there are two interrupt request outputs, one per side.
// R5: each interrupt output is active low open drain, pulling only low.
// R6: the data lines are released except during a selected read.
// R7: a cycle is answered only with both high selects high, low select low.
// R8: the two register picks choose which register the cycle reaches.
// R9: an interrupt input must be held active at least 500 ns to be seen; the code registers it on every clock, so one clock is enough.
// R10: picks 0/2 reach side data or direction by control bit 2, 1/3 control.
// R11: write data is latched in phase two and stored after its trailing edge.
// R12: when not selected the direction, picks and data are ignored.
`ifndef PHP_CONSTS_SVH
`define PHP_CONSTS_SVH
`define PHP_DATA_W        8
`define PHP_PICK_PORT_A   2'h0
`define PHP_PICK_CTRL_A   2'h1
`define PHP_PICK_PORT_B   2'h2
`define PHP_PICK_CTRL_B   2'h3
`define PHP_CTRL_SEL_BIT  2
`define PHP_CTRL_IRQ1_BIT 7
`define PHP_CTRL_IRQ2_BIT 6
`define PHP_RESET_VAL     8'h00
`define PHP_IRQ_PULSE_NS  500
`define PHP_CLK_PERIOD_NS 4
`define PHP_IRQ_PULSE_CYC \
   ((`PHP_IRQ_PULSE_NS + `PHP_CLK_PERIOD_NS - 1) / `PHP_CLK_PERIOD_NS)
`endif

// ==== core/php_pkg.sv ====
package php_pkg;
   typedef struct packed {
      logic       sel_hi_first;
      logic       sel_hi_second;
      logic       sel_lo_n;
      logic [1:0] pick;
      logic       rd_not_wr;
   } php_bus_t;
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] direction;
      logic [7:0] control;
   } php_side_t;
endpackage

// ==== core/php_host_port.sv ====
`timescale 1ns/100ps
`include "php_consts.svh"
module php_host_port #(
   parameter int DATA_W = `PHP_DATA_W
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              init_low_input_n_in,
   input  wire logic              phase_two_in,
   input  wire php_pkg::php_bus_t bus_in,
   input  wire logic [DATA_W-1:0] host_data_bus_in,
   output logic [DATA_W-1:0]      host_data_bus_out,
   output logic                   host_data_bus_oe_out,
   input  wire logic [DATA_W-1:0] side_a_pins_in,
   input  wire logic [DATA_W-1:0] side_b_pins_in,
   input  wire logic              side_a_irq_src_in,
   input  wire logic              side_b_irq_src_in,
   output logic                   side_a_irq_n_out,
   output logic                   side_a_irq_n_oe_out,
   output logic                   side_b_irq_n_out,
   output logic                   side_b_irq_n_oe_out,
   output php_pkg::php_side_t     side_a_out,
   output php_pkg::php_side_t     side_b_out
);
   php_pkg::php_side_t a_reg;
   php_pkg::php_side_t b_reg;
   logic [DATA_W-1:0]  latch_reg;
   logic [1:0]         pick_reg;
   logic               wr_pend_reg;
   logic               p2_reg;
   logic               irq_a_reg;
   logic               irq_b_reg;
   logic [DATA_W-1:0]  rd_next;
   logic               selected;
   logic               trail;

   assign selected = bus_in.sel_hi_first && bus_in.sel_hi_second
                     && !bus_in.sel_lo_n; // R7
   assign trail = p2_reg && !phase_two_in; // R11

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         p2_reg <= 1'b0;
      end else if (!init_low_input_n_in) begin
         p2_reg <= 1'b0; // R1
      end else begin
         p2_reg <= phase_two_in;
      end
   end

   // latch during phase two, hold pick for the trailing edge
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         latch_reg   <= `PHP_RESET_VAL;
         pick_reg    <= 2'h0;
         wr_pend_reg <= 1'b0;
      end else if (!init_low_input_n_in) begin
         latch_reg   <= `PHP_RESET_VAL; // R1
         pick_reg    <= 2'h0;
         wr_pend_reg <= 1'b0;
      end else if (phase_two_in && selected && !bus_in.rd_not_wr) begin
         latch_reg   <= host_data_bus_in; // R2 R3 R11
         pick_reg    <= bus_in.pick;
         wr_pend_reg <= 1'b1;
      end else if (trail || !phase_two_in) begin
         wr_pend_reg <= 1'b0; // R12
      end
   end

   // register store after trailing edge
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         a_reg <= '0;
         b_reg <= '0;
      end else if (!init_low_input_n_in) begin
         a_reg <= '0; // R1
         b_reg <= '0;
      end else if (trail && wr_pend_reg) begin
         unique case (pick_reg) // R8 R10
            `PHP_PICK_PORT_A: begin
               if (a_reg.control[`PHP_CTRL_SEL_BIT]) a_reg.data <= latch_reg;
               else a_reg.direction <= latch_reg;
            end
            `PHP_PICK_CTRL_A: a_reg.control[5:0] <= latch_reg[5:0];
            `PHP_PICK_PORT_B: begin
               if (b_reg.control[`PHP_CTRL_SEL_BIT]) b_reg.data <= latch_reg;
               else b_reg.direction <= latch_reg;
            end
            `PHP_PICK_CTRL_B: b_reg.control[5:0] <= latch_reg[5:0];
         endcase
      end
   end

   // interrupt sources, sampled once per cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
      end else if (!init_low_input_n_in) begin
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
      end else begin
         irq_a_reg <= side_a_irq_src_in; // R4 R9
         irq_b_reg <= side_b_irq_src_in;
      end
   end

   // read mux, pins for side a data, side b outputs from its data register, control with live flags
   always_comb begin
      rd_next = '0;
      unique case (bus_in.pick) // R8 R10
         `PHP_PICK_PORT_A: rd_next = a_reg.control[`PHP_CTRL_SEL_BIT]
                                     ? side_a_pins_in : a_reg.direction;
         `PHP_PICK_CTRL_A: rd_next = {irq_a_reg, 1'b0, a_reg.control[5:0]};
         `PHP_PICK_PORT_B: rd_next = b_reg.control[`PHP_CTRL_SEL_BIT]
                                     ? ((b_reg.data & b_reg.direction)
                                        | (side_b_pins_in & ~b_reg.direction))
                                     : b_reg.direction;
         `PHP_PICK_CTRL_B: rd_next = {irq_b_reg, 1'b0, b_reg.control[5:0]};
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         host_data_bus_out <= `PHP_RESET_VAL;
      end else if (!init_low_input_n_in) begin
         host_data_bus_out <= `PHP_RESET_VAL; // R1
      end else begin
         host_data_bus_out <= rd_next;
      end
   end

   assign host_data_bus_oe_out = phase_two_in && selected
                                 && bus_in.rd_not_wr; // R6 R3
   assign side_a_irq_n_out    = 1'b0; // R5
   assign side_a_irq_n_oe_out = irq_a_reg; // R4 R5
   assign side_b_irq_n_out    = 1'b0;
   assign side_b_irq_n_oe_out = irq_b_reg;
   assign side_a_out = a_reg;
   assign side_b_out = b_reg;

   // guards on the bus side and the stored registers
   chk_drive_only_read: assert property (@(posedge clk_in) disable iff (rst_in)
      host_data_bus_oe_out |-> selected && bus_in.rd_not_wr && phase_two_in)
      else $error("data bus driven outside selected read"); // R6
   chk_irq_follows_src: assert property (@(posedge clk_in) disable iff (rst_in)
      init_low_input_n_in && side_a_irq_src_in |=> side_a_irq_n_oe_out
      || !$past(init_low_input_n_in))
      else $error("side a interrupt not raised"); // R4
   chk_init_clears: assert property (@(posedge clk_in) disable iff (rst_in)
      !init_low_input_n_in |=> a_reg == '0 && b_reg == '0)
      else $error("init did not clear registers"); // R1
   chk_store_on_trail: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(a_reg) && $past(init_low_input_n_in) |-> $past(trail)
      && $past(wr_pend_reg))
      else $error("register changed outside trailing edge"); // R11 R2
   chk_unsel_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
      phase_two_in && !selected && !wr_pend_reg && init_low_input_n_in
      |=> !wr_pend_reg)
      else $error("unselected cycle started a write"); // R12 R7
   chk_ctrl_pick: assert property (@(posedge clk_in) disable iff (rst_in)
      trail && wr_pend_reg && pick_reg == `PHP_PICK_CTRL_B
      && init_low_input_n_in |=> b_reg.control[5:0] == $past(latch_reg[5:0]))
      else $error("control b not written"); // R10 R8
   chk_read_no_store: assert property (@(posedge clk_in) disable iff (rst_in)
      phase_two_in && selected && bus_in.rd_not_wr && !wr_pend_reg
      |=> !wr_pend_reg)
      else $error("read cycle latched a write"); // R3
   chk_irq_pull_low: assert property (@(posedge clk_in) disable iff (rst_in)
      side_b_irq_n_oe_out |-> !side_b_irq_n_out)
      else $error("irq line driven high"); // R5

   // bus steps: write latch during phase two, store on its trailing edge, selected read
   sequence s_wr_latch;
      phase_two_in && selected && !bus_in.rd_not_wr && init_low_input_n_in;
   endsequence
   sequence s_trail_store;
      trail && wr_pend_reg && init_low_input_n_in;
   endsequence
   sequence s_sel_read;
      phase_two_in && selected && bus_in.rd_not_wr && init_low_input_n_in;
   endsequence

   chk_latch_write: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_latch |=> wr_pend_reg && latch_reg == $past(host_data_bus_in))
      else $error("write data not latched"); // R11 R3
   chk_trail_ends: assert property (@(posedge clk_in) disable iff (rst_in)
      s_trail_store |=> !wr_pend_reg)
      else $error("pending write not retired"); // R11
   chk_dir_a_store: assert property (@(posedge clk_in) disable iff (rst_in)
      s_trail_store ##0 (pick_reg == `PHP_PICK_PORT_A
      && !a_reg.control[`PHP_CTRL_SEL_BIT])
      |=> a_reg.direction == $past(latch_reg))
      else $error("direction a not written"); // R10 R8
   chk_data_a_store: assert property (@(posedge clk_in) disable iff (rst_in)
      s_trail_store ##0 (pick_reg == `PHP_PICK_PORT_A
      && a_reg.control[`PHP_CTRL_SEL_BIT])
      |=> a_reg.data == $past(latch_reg))
      else $error("data a not written"); // R10 R8
   chk_dir_b_store: assert property (@(posedge clk_in) disable iff (rst_in)
      s_trail_store ##0 (pick_reg == `PHP_PICK_PORT_B
      && !b_reg.control[`PHP_CTRL_SEL_BIT])
      |=> b_reg.direction == $past(latch_reg))
      else $error("direction b not written"); // R10 R8
   chk_data_b_store: assert property (@(posedge clk_in) disable iff (rst_in)
      s_trail_store ##0 (pick_reg == `PHP_PICK_PORT_B
      && b_reg.control[`PHP_CTRL_SEL_BIT])
      |=> b_reg.data == $past(latch_reg))
      else $error("data b not written"); // R10 R8
   chk_b_store_trail: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(b_reg) && $past(init_low_input_n_in) |-> $past(trail)
      && $past(wr_pend_reg))
      else $error("register b changed outside trailing edge"); // R11 R2
   chk_ctrl_top_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      a_reg.control[7:6] == 2'h0 && b_reg.control[7:6] == 2'h0)
      else $error("control status bits were written"); // R10
   chk_read_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      s_sel_read ##0 (bus_in.pick == `PHP_PICK_CTRL_B)
      |=> host_data_bus_out[7:6] == {$past(side_b_irq_n_oe_out), 1'b0})
      else $error("control b read lost the flag"); // R4 R10
   chk_irq_b_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      init_low_input_n_in && side_b_irq_src_in |=> side_b_irq_n_oe_out)
      else $error("side b interrupt not raised"); // R4
   chk_init_irq_off: assert property (@(posedge clk_in) disable iff (rst_in)
      !init_low_input_n_in |=> !side_a_irq_n_oe_out && !side_b_irq_n_oe_out)
      else $error("init left an interrupt pulled"); // R1 R5
   chk_idle_released: assert property (@(posedge clk_in) disable iff (rst_in)
      !phase_two_in |-> !host_data_bus_oe_out)
      else $error("data bus driven outside phase two"); // R2 R6
endmodule

// ==== dv/php_cpu_model.sv ====
`timescale 1ns/100ps
module php_cpu_model (
   input  wire logic         clk_in,
   input  wire logic         oe_in,
   input  wire logic [7:0]   dev_in,
   output logic              p2_out,
   output php_pkg::php_bus_t bus_out,
   output wire logic [7:0]   wire_out
);
   logic [7:0] drv_reg;
   logic       drv_en;
   logic [7:0] last_reg;
   // released bus shows the inverse of its last value
   assign wire_out = oe_in ? dev_in : (drv_en ? drv_reg : ~last_reg);
   always @(posedge clk_in) begin
      if (oe_in || drv_en) last_reg <= wire_out;
   end
   initial begin
      p2_out = 1'b0;
      bus_out = 6'h08;
      drv_en = 1'b0;
      drv_reg = 8'h00;
      last_reg = 8'h00;
   end
   task automatic xfer(input logic [2:0] sel, input logic [1:0] pick,
      input logic rd, input logic [7:0] d, input logic p2,
      output logic [7:0] q, output logic qo);
      @(negedge clk_in);
      bus_out = {sel, pick, rd};
      drv_reg = d;
      drv_en = !rd;
      p2_out = p2;
      repeat (3) @(negedge clk_in);
      q = wire_out;
      qo = oe_in;
      p2_out = 1'b0;
      @(negedge clk_in);
      bus_out = 6'h08;
      drv_en = 1'b0;
   endtask
endmodule

// ==== dv/php_host_port_bench.sv ====
`timescale 1ns/100ps
`include "php_consts.svh"
module php_host_port_bench;
   logic               clk_in = 0, rst_in = 1, init_n = 1, p2, qo;
   logic               sa = 0, sb = 0, oe, ia, iao, ib, ibo;
   logic [7:0]         pa = 8'hA5, pb = 8'h3C, dq, bw, q;
   php_pkg::php_bus_t  bus;
   php_pkg::php_side_t a, b;
   int                 err_total = 0, checked = 0;
   initial forever #2 clk_in = ~clk_in;
   php_host_port dut_u (.clk_in(clk_in), .rst_in(rst_in),
      .init_low_input_n_in(init_n), .phase_two_in(p2), .bus_in(bus),
      .host_data_bus_in(bw), .host_data_bus_out(dq),
      .host_data_bus_oe_out(oe), .side_a_pins_in(pa),
      .side_b_pins_in(pb), .side_a_irq_src_in(sa),
      .side_b_irq_src_in(sb), .side_a_irq_n_out(ia),
      .side_a_irq_n_oe_out(iao), .side_b_irq_n_out(ib),
      .side_b_irq_n_oe_out(ibo), .side_a_out(a), .side_b_out(b));
   php_cpu_model cpu_u (.clk_in(clk_in), .oe_in(oe), .dev_in(dq),
      .p2_out(p2), .bus_out(bus), .wire_out(bw));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic go(input logic [2:0] s, input logic [1:0] k,
      input logic rd, input logic [7:0] d, input logic p);
      cpu_u.xfer(s, k, rd, d, p, q, qo);
      @(negedge clk_in);
   endtask
   task automatic t_map;
      go(3'h6, 2'h1, 0, 8'h00, 1);
      go(3'h6, 2'h0, 0, 8'h0F, 1);
      cmp(a.direction, 8'h0F);
      go(3'h6, 2'h1, 0, 8'h04, 1);
      go(3'h6, 2'h0, 0, 8'h5A, 1);
      cmp(a.data, 8'h5A);
      cmp(a.direction, 8'h0F);
      go(3'h6, 2'h3, 0, 8'h04, 1);
      go(3'h6, 2'h2, 0, 8'hC3, 1);
      cmp(b.data, 8'hC3);
      cmp(b.direction, 8'h00);
   endtask
   task automatic t_sel;
      logic [2:0] bad [4] = '{3'h2, 3'h4, 3'h7, 3'h0};
      foreach (bad[i]) begin
         go(bad[i], 2'h1, 0, 8'h3B, 1);
         cmp(a.control, 8'h04);
         go(bad[i], 2'h1, 1, 8'h00, 1);
         cmp({7'h0, qo}, 8'h00);
      end
      go(3'h6, 2'h1, 0, 8'h3B, 0);
      cmp(a.control, 8'h04);
   endtask
   task automatic t_read;
      go(3'h6, 2'h0, 1, 8'h00, 1);
      cmp(q, pa);
      cmp({7'h0, qo}, 8'h01);
      go(3'h6, 2'h2, 1, 8'h00, 1);
      cmp(q, pb);
      go(3'h6, 2'h3, 1, 8'h00, 1);
      cmp(q, 8'h04);
      go(3'h6, 2'h3, 0, 8'h00, 1);
      go(3'h6, 2'h2, 0, 8'hF0, 1);
      go(3'h6, 2'h2, 1, 8'h00, 1);
      cmp(q, 8'hF0);
      go(3'h6, 2'h3, 0, 8'h04, 1);
      go(3'h6, 2'h2, 1, 8'h00, 1);
      cmp(q, 8'hCC);
   endtask
   task automatic t_irq;
      sa = 1'b1;
      repeat (`PHP_IRQ_PULSE_CYC + 5) @(negedge clk_in);
      cmp({6'h0, ibo ? ib : 1'b1, iao ? ia : 1'b1}, 8'h02);
      go(3'h6, 2'h1, 1, 8'h00, 1);
      cmp(q, 8'h84);
      sa = 1'b0;
      sb = 1'b1;
      repeat (`PHP_IRQ_PULSE_CYC + 5) @(negedge clk_in);
      cmp({6'h0, ibo ? ib : 1'b1, iao ? ia : 1'b1}, 8'h01);
      go(3'h6, 2'h3, 1, 8'h00, 1);
      cmp(q, 8'h84);
      sb = 1'b0;
   endtask
   task automatic t_init;
      init_n = 1'b0;
      repeat (2) @(negedge clk_in);
      init_n = 1'b1;
      cmp(a.control, 8'h00);
      cmp(b.data, 8'h00);
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      @(negedge clk_in) rst_in = 1'b0;
      cmp(a.control | b.direction, 8'h00);
      t_map();
      t_sel();
      t_read();
      t_irq();
      t_init();
      summarize();
   end
   initial begin
      #20000;
      err_total++;
      summarize();
   end
endmodule
